// ===== dv/grip_cmd_bench.sv
// Self-checking bench for the gripper command interpreter
`timescale 1ns/100ps
module grip_cmd_bench;
   import grip_cmd_pkg::*;
   typedef struct {int k; int b; logic [15:0] v;} note_t;
   logic        sys_clk, rst_n, motion_busy, timed_out, overrun_stop;
   logic [15:0] command_word, outer_target, switch_point, learned_point, inner_limit;
   logic [15:0] actual_position, state_flags, diagnosis;
   logic [7:0]  operating_selector, recipe_index, position_window;
   logic [7:0]  clamp_force_pct, travel_speed_pct;
   move_t       move_req;
   int          num_errors, checks, cycles;
   note_t       notes[$];
   event        look;

   plc_master u_plc_master (.sys_clk, .state_flags, .command_word, .operating_selector,
      .recipe_index, .timed_out);
   grip_cmd u_grip_cmd (.sys_clk, .rst_n, .command_word, .operating_selector, .recipe_index,
      .position_window, .clamp_force_pct, .travel_speed_pct, .outer_target, .switch_point,
      .learned_point, .inner_limit, .actual_position, .motion_busy, .state_flags,
      .diagnosis, .ctrl_mode_valid(), .ctrl_mode(), .ctrl_reset(), .motor_enable(),
      .move_req, .overrun_stop, .overrun_limit(), .active_set());

   // ------------------------------------------------------------
   // Clock, watchdog and verdict
   // ------------------------------------------------------------
   initial sys_clk = 1'b0;
   always #2.5 sys_clk = ~sys_clk;

   task automatic give_verdict;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Generous ceiling; the run needs well under a hundred cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 4000 || timed_out === 1'b1) begin
         num_errors++;
         give_verdict();
      end
   end

   // ------------------------------------------------------------
   // Notes and the watching process
   // ------------------------------------------------------------
   task automatic note(input int k, input int b, input logic [15:0] v);
      notes.push_back('{k, b, v});
   endtask

   // Settle, compare, then on to the next edge
   task automatic verify;
      #1 -> look;
      @(posedge sys_clk);
      #1;
   endtask

   task automatic cmp_move(input move_t e);
      checks++;
      if (move_req !== e) begin
         num_errors++;
         $display("ERROR %0t move_req %0h expected %0h", $time, move_req, e);
      end
   endtask

   task automatic cmp_word(input logic [15:0] a, input logic [15:0] e);
      checks++;
      if (a !== e) begin
         num_errors++;
         $display("ERROR %0t word %0h expected %0h", $time, a, e);
      end
   endtask

   always begin
      note_t n;
      @(look);
      while (notes.size() > 0) begin
         n = notes.pop_front();
         case (n.k)
            0: cmp_move(move_t'(n.v[4:0]));
            1: cmp_word(diagnosis, n.v);
            3: cmp_word(16'(overrun_stop), n.v);
            default: cmp_word({15'h0000, state_flags[n.b]}, n.v);
         endcase
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(81));
      {rst_n, motion_busy, num_errors, checks, cycles} = '0;
      {position_window, clamp_force_pct, travel_speed_pct} = {8'h96, 8'h32, 8'h4b};
      {outer_target, switch_point, learned_point, inner_limit} = 64'h03e8_07d0_05dc_0bb8;
      actual_position = 16'h0000;
      repeat (8) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      // Motor on; no motion until a move bit, window edges
      u_plc_master.handshake(SEL_MOTOR_ON, 8'h00);
      note(2, SF_MOTOR_ON, 1);
      note(0, 0, MV_STOP);
      actual_position = 16'h047e;
      note(2, SF_AT_OUTER, 1);
      verify();
      actual_position = 16'h047f;
      note(2, SF_AT_OUTER, 0);
      note(2, SF_UNDEFINED, 1);
      verify();
      for (int i = 0; i < 4; i++) begin
         actual_position = 16'h0bb8 - 16'($urandom_range(150));
         motion_busy = 1'($urandom_range(1));
         note(2, SF_AT_INNER, 1);
         note(2, SF_IN_MOTION, {15'h0000, motion_busy});
         verify();
      end
      $display("test window done");
      // Moves, heading flag and its clearing
      u_plc_master.pulse(16'h0100, 8'h00);
      note(0, 0, MV_OUTER);
      note(2, SF_HEAD_OUTER, 1);
      verify();
      u_plc_master.pulse(16'h0004, 8'h00);
      note(2, SF_HEAD_OUTER, 0);
      verify();
      u_plc_master.pulse(16'h0200, 8'h00);
      note(0, 0, MV_INNER);
      verify();
      // Idle refuses; then reset and a zero selector
      u_plc_master.handshake(SEL_IDLE, 8'h00);
      u_plc_master.pulse(16'h0100, 8'h00);
      note(2, SF_HEAD_OUTER, 0);
      verify();
      u_plc_master.handshake(SEL_CTRL_RST, 8'h00);
      u_plc_master.handshake(SEL_NONE, 8'h00);
      $display("test moves done");
      // Jog in both directions, halting on release
      u_plc_master.handshake(SEL_MOTOR_ON, 8'h00);
      u_plc_master.handshake(SEL_JOG, 8'h00);
      for (int i = 0; i < 2; i++) begin
         u_plc_master.set_word(i ? 16'h0800 : 16'h0400);
         note(0, 0, i ? MV_CREEP_OUTER : MV_CREEP_INNER);
         verify();
         u_plc_master.set_word(16'h0000);
         note(0, 0, MV_STOP);
         verify();
      end
      u_plc_master.handshake(SEL_MOTOR_OFF, 8'h00);
      note(2, SF_MOTOR_ON, 0);
      note(0, 0, MV_STOP);
      verify();
      $display("test jog done");
      // Ordering fault, index range, then recovery
      outer_target = 16'h09c4;
      u_plc_master.handshake(SEL_MOTOR_ON, 8'h00);
      u_plc_master.pulse(16'h0100, 8'h00);
      note(1, 0, DIAG_ORDER);
      note(2, SF_ERROR, 1);
      note(0, 0, MV_STOP);
      verify();
      outer_target = 16'h03e8;
      u_plc_master.handshake(SEL_MOTOR_ON, 8'h21);
      note(1, 0, DIAG_RANGE);
      verify();
      u_plc_master.handshake(SEL_MOTOR_ON, 8'h00);
      note(1, 0, DIAG_OK);
      verify();
      $display("test faults done");
      // Store, teach, then load the recipe over a zero window
      u_plc_master.pulse(16'h0002, 8'h05);
      actual_position = 16'h04d2;
      u_plc_master.pulse(16'h0008, 8'h05);
      position_window = 8'h00;
      u_plc_master.handshake(SEL_MOTOR_ON, 8'h05);
      actual_position = 16'h043c;
      note(2, SF_AT_LEARNED, 1);
      verify();
      actual_position = 16'h0bb8;
      u_plc_master.handshake(SEL_OVR_B, 8'h00);
      note(3, 0, 1);
      verify();
      $display("test recipe done");
      give_verdict();
   end
endmodule

// ===== dv/grip_cmd_sva.sv
// Assertion checker for the gripper command interpreter
`timescale 1ns/100ps
module grip_cmd_sva (
   input wire logic                      sys_clk,            // Clock
   input wire logic                      rst_n,              // Async reset
   input wire logic [15:0]               command_word,       // Cyclic command
   input wire logic [7:0]                operating_selector, // Cyclic mode
   input wire logic [15:0]               actual_position,    // Measured position
   input wire logic [15:0]               state_flags,        // Status word
   input wire logic [15:0]               diagnosis,          // Fault code
   input wire logic                      ctrl_mode_valid,    // Selector forwarded
   input wire logic [7:0]                ctrl_mode,          // Forwarded selector
   input wire logic                      ctrl_reset,         // Reset pulse
   input wire logic                      motor_enable,       // Motor stage
   input wire grip_cmd_pkg::move_t       move_req,           // Motion request
   input wire grip_cmd_pkg::param_set_t  active_set          // Active set
);
   import grip_cmd_pkg::*;

   // ------------------------------------------------------------
   // Window helper, 17 bits so the edges never wrap
   // ------------------------------------------------------------
   logic [16:0] pos_x;
   logic        in_outer;
   assign pos_x    = {1'b0, actual_position};
   assign in_outer = (pos_x + active_set.window >= {1'b0, active_set.outer})
                  && (pos_x <= {1'b0, active_set.outer} + active_set.window);

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   chk_ack_rise: assert property (
      command_word == CW_BASIC && $past(command_word) == 16'h0000
      |=> state_flags[SF_COMMIT_ACK]) else $error("ack did not rise");
   chk_ack_drop: assert property (
      state_flags[SF_COMMIT_ACK] && command_word == 16'h0000
      |=> !state_flags[SF_COMMIT_ACK]) else $error("ack did not drop");
   chk_mode_nonzero: assert property (
      ctrl_mode_valid |-> ctrl_mode != SEL_NONE) else $error("zero mode forwarded");
   chk_ctrl_reset: assert property (
      command_word == CW_BASIC && $past(command_word) == 16'h0000
      && operating_selector == SEL_CTRL_RST |=> ctrl_reset ##1 !ctrl_reset)
      else $error("controller reset pulse wrong");
   chk_motor_off: assert property (
      command_word == CW_BASIC && $past(command_word) == 16'h0000
      && operating_selector == SEL_MOTOR_OFF |=> !motor_enable && move_req == MV_STOP)
      else $error("motor off did not halt");
   chk_idle_block: assert property (
      ctrl_mode_valid && ctrl_mode == SEL_IDLE && command_word == 16'h0100
      && $past(command_word) == 16'h0000 |=> $stable(move_req))
      else $error("move accepted while idle");
   chk_creep_halt: assert property (
      (move_req == MV_CREEP_INNER || move_req == MV_CREEP_OUTER)
      && command_word == 16'h0000 |=> move_req == MV_STOP) else $error("creep kept going");
   chk_win_outer: assert property (
      state_flags[SF_AT_OUTER] == in_outer) else $error("outer window flag wrong");
   chk_fault_flag: assert property (
      diagnosis != DIAG_OK |-> state_flags[SF_ERROR]) else $error("error flag missing");
   chk_fault_hold: assert property (
      diagnosis == DIAG_ORDER && command_word == 16'h0100
      && $past(command_word) == 16'h0000 |=> $stable(move_req))
      else $error("move started despite order fault");
endmodule

bind grip_cmd grip_cmd_sva u_grip_cmd_sva (.sys_clk, .rst_n, .command_word,
   .operating_selector, .actual_position, .state_flags, .diagnosis, .ctrl_mode_valid,
   .ctrl_mode, .ctrl_reset, .motor_enable, .move_req, .active_set);

// ===== dv/plc_master.sv
// Fieldbus master model driving the cyclic command data
`timescale 1ns/100ps
module plc_master (
   input  wire logic        sys_clk,            // Clock
   input  wire logic [15:0] state_flags,        // Device status
   output logic [15:0]      command_word,       // Cyclic command
   output logic [7:0]       operating_selector, // Cyclic mode
   output logic [7:0]       recipe_index,       // Recipe slot
   output logic             timed_out           // Ack never came
);
   import grip_cmd_pkg::*;

   // Idle word at power up; zero is a legal word
   initial begin
      command_word       = 16'h0000;
      operating_selector = SEL_IDLE;
      recipe_index       = 8'h00;
      timed_out          = 1'b0;
   end

   // Bounded wait so a dead device cannot hang the run
   task automatic wait_ack(input logic lvl);
      int n = 0;
      while (state_flags[SF_COMMIT_ACK] !== lvl && n < 20) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      if (n == 20) timed_out = 1'b1;
   endtask

   // Basic selectors always travel with the commit word
   task automatic handshake(input logic [7:0] sel, input logic [7:0] idx);
      operating_selector = sel;
      recipe_index       = idx;
      command_word       = CW_BASIC;
      wait_ack(1'b1);
      command_word = 16'h0000;
      wait_ack(1'b0);
   endtask

   // Single bit for one cycle, then back to zero
   task automatic pulse(input logic [15:0] cw, input logic [7:0] idx);
      recipe_index = idx;
      set_word(cw);
      set_word(16'h0000);
   endtask

   // Held word for jogging; lands at the next edge
   task automatic set_word(input logic [15:0] cw);
      command_word = cw;
      @(posedge sys_clk);
      #1;
   endtask
endmodule

// ===== logic/grip_cmd.sv
// Process data command interpreter of the electric gripper
//
// Behaviour
// - Commit bit adopts cyclic set when index zero, else stored recipe 1..32.
// - Store bit writes the received cyclic parameters into the selected recipe slot.
// - Clear-heading bit clears the direction flag so same target may repeat.
// - Teach stores present position as learned point in selected recipe; not at 0.
// - Go-outer starts move to outer target; go-inner starts move to inner limit.
// - Creep bits move slowly while held and stop as soon as released.
// - Selector zero is never forwarded to the motor controller.
// - Selector one (idle) rejects every movement request.
// - Selector two resets the motor controller.
// - Selector three enables motor; motion waits for a later move bit.
// - Selector five switches motor off and halts all motion.
// - Selector eleven selects jog; withdrawing the creep bit halts at once.
// - Recipe index is 0..32; nonzero with commit loads that recipe.
// - Window is 0.01 mm per count, applied on both sides of each target.
// - Force percentage limited to 1..100.
// - Speed percentage 1..100, scaled against the maximum speed.
// - Outer below switch point below inner limit, otherwise report error.
// - Flags 8, 9, 10 show position within window of outer, learned, inner.
// - All 16-bit targets count in hundredths of a millimetre.
// - In selectors 60 and 80 stop begins at inner limit, overrun at most 2 mm.
// - Commit handshake: ack flag 12 rises on commit, drops after word zero.
// - Flag 13 set after a move toward outer target; clear-heading clears it.
`timescale 1ns/100ps

module grip_cmd
   import grip_cmd_pkg::*;
(
   input  wire logic                 sys_clk,            // 200 MHz clock
   input  wire logic                 rst_n,              // Async reset, low active
   input  wire logic [15:0]          command_word,       // Cyclic one-hot command
   input  wire logic [7:0]           operating_selector, // Cyclic operating mode
   input  wire logic [7:0]           recipe_index,       // Recipe slot 0..32
   input  wire logic [7:0]           position_window,    // Window, 0.01 mm
   input  wire logic [7:0]           clamp_force_pct,    // Force 1..100 %
   input  wire logic [7:0]           travel_speed_pct,   // Speed 1..100 %
   input  wire logic [15:0]          outer_target,       // Outer target, 0.01 mm
   input  wire logic [15:0]          switch_point,       // Switch point, 0.01 mm
   input  wire logic [15:0]          learned_point,      // Learned point, 0.01 mm
   input  wire logic [15:0]          inner_limit,        // Inner limit, 0.01 mm
   input  wire logic [15:0]          actual_position,    // Measured jaw position
   input  wire logic                 motion_busy,        // Drive reports motion
   output logic [15:0]               state_flags,        // Status word
   output logic [15:0]               diagnosis,          // Fault code
   output logic                      ctrl_mode_valid,    // Selector forwarded
   output logic [7:0]                ctrl_mode,          // Forwarded selector
   output logic                      ctrl_reset,         // Controller reset pulse
   output logic                      motor_enable,       // Motor stage on
   output grip_cmd_pkg::move_t       move_req,           // Requested motion
   output logic                      overrun_stop,       // Begin stopping
   output logic [15:0]               overrun_limit,      // Farthest stop point
   output grip_cmd_pkg::param_set_t  active_set          // Active parameters
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      param_set_t  act;
      logic [15:0] cw_prev;
      logic        ack;
      logic        head_outer;
      logic        head_inner;
      logic        motor;
      logic        ctrl_rst;
      logic        mode_vld;
      logic [7:0]  mode;
      logic        err;
      logic [15:0] diag;
      move_t       mv;
      logic        ovr_stop;
   } state_t;

   state_t s_q;
   state_t s_d;

   // Recipe memory, slot 0 unused so the index maps directly
   param_set_t recipe_mem [1:RECIPE_MAX];

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Window test in 17 bits so edges near 0 or full scale do not wrap
   function automatic logic in_window(input logic [15:0] pos,
                                      input logic [15:0] tgt,
                                      input logic [7:0]  win);
      logic [16:0] lo;
      logic [16:0] hi;
      lo = {1'b0, tgt} - {9'h000, win};
      hi = {1'b0, tgt} + {9'h000, win};
      if ({1'b0, tgt} < {9'h000, win}) begin
         lo = 17'h0_0000;
      end
      return ({1'b0, pos} >= lo) && ({1'b0, pos} <= hi);
   endfunction

   function automatic logic [7:0] clamp_pct(input logic [7:0] v);
      if (v < PCT_MIN) begin
         return PCT_MIN;
      end
      if (v > PCT_MAX) begin
         return PCT_MAX;
      end
      return v;
   endfunction

   function automatic logic order_ok(input param_set_t p);
      return (p.outer < p.shift) && (p.shift < p.inner);
   endfunction

   // ---------------------------------------------------------------
   // Decode of the cyclic inputs
   // ---------------------------------------------------------------
   param_set_t cyc;
   logic       idx_ok;
   logic       idx_slot;
   logic       one_hot;
   logic [15:0] rise;
   logic       basic_sel;

   always_comb begin
      cyc.window    = position_window;
      cyc.force_pct = clamp_pct(clamp_force_pct);
      cyc.speed_pct = clamp_pct(travel_speed_pct);
      cyc.outer     = outer_target;
      cyc.shift     = switch_point;
      cyc.learned   = learned_point;
      cyc.inner     = inner_limit;
      idx_ok        = recipe_index <= RECIPE_MAX;
      idx_slot      = idx_ok && (recipe_index != 8'h00);
      // Bad multi-bit words are ignored rather than guessed at
      one_hot       = (command_word & (command_word - 16'h0001)) == 16'h0000;
      rise          = command_word & ~s_q.cw_prev;
      basic_sel     = (operating_selector == SEL_IDLE) || (operating_selector == SEL_CTRL_RST)
                      || (operating_selector == SEL_MOTOR_ON)
                      || (operating_selector == SEL_MOTOR_OFF);
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   param_set_t cand;
   logic       commit_now;

   always_comb begin
      s_d          = s_q;
      s_d.cw_prev  = command_word;
      s_d.ctrl_rst = 1'b0;
      cand         = cyc;
      commit_now   = one_hot && rise[CW_PARAM_COMMIT];

      // Commit of a new set and selector, acknowledged until word zero
      if (commit_now) begin
         if (idx_slot) begin
            cand = recipe_mem[recipe_index[5:0]];
         end
         if (!idx_ok) begin
            s_d.err  = 1'b1;
            s_d.diag = DIAG_RANGE;
         end else if (!order_ok(cand)) begin
            s_d.err  = 1'b1;
            s_d.diag = DIAG_ORDER;
         end else begin
            s_d.act  = cand;
            s_d.err  = 1'b0;
            s_d.diag = DIAG_OK;
         end
         s_d.ack = 1'b1;
         if (operating_selector != SEL_NONE) begin
            s_d.mode_vld = 1'b1;
            s_d.mode     = operating_selector;
            // Basic commands are only taken with the commit word
            if (basic_sel && command_word == CW_BASIC) begin
               unique case (operating_selector)
                  SEL_IDLE:      s_d.mv = MV_STOP;
                  SEL_CTRL_RST:  s_d.ctrl_rst = 1'b1;
                  SEL_MOTOR_ON:  s_d.motor = 1'b1;
                  SEL_MOTOR_OFF: begin
                     s_d.motor = 1'b0;
                     s_d.mv    = MV_STOP;
                  end
               endcase
            end
         end
      end else if (command_word == 16'h0000) begin
         s_d.ack = 1'b0;
      end

      // Direction flag clear
      if (one_hot && rise[CW_CLEAR_HEADING]) begin
         s_d.head_outer = 1'b0;
         s_d.head_inner = 1'b0;
      end

      // Move starts: idle or a bad order blocks, same target needs a clear
      if (one_hot && (rise[CW_GO_OUTER] || rise[CW_GO_INNER])) begin
         if (s_q.mode == SEL_IDLE || !s_q.motor) begin
            s_d.mv = s_q.mv;
         end else if (!order_ok(s_q.act) || s_q.err) begin
            s_d.err  = 1'b1;
            s_d.diag = DIAG_ORDER;
         end else if (rise[CW_GO_OUTER] && !s_q.head_outer) begin
            s_d.mv         = MV_OUTER;
            s_d.head_outer = 1'b1;
            s_d.head_inner = 1'b0;
         end else if (rise[CW_GO_INNER] && !s_q.head_inner) begin
            s_d.mv         = MV_INNER;
            s_d.head_inner = 1'b1;
            s_d.head_outer = 1'b0;
         end
      end

      // Creep only while its bit is held, in jog mode
      if (s_q.mode == SEL_JOG && s_q.motor && one_hot
          && command_word[CW_CREEP_INNER]) begin
         s_d.mv = MV_CREEP_INNER;
      end else if (s_q.mode == SEL_JOG && s_q.motor && one_hot
                   && command_word[CW_CREEP_OUTER]) begin
         s_d.mv = MV_CREEP_OUTER;
      end else if (s_q.mv == MV_CREEP_INNER || s_q.mv == MV_CREEP_OUTER) begin
         s_d.mv = MV_STOP;
      end

      // Idle and motor off hold the drive still whatever arrives
      if (s_q.mode == SEL_IDLE || !s_d.motor) begin
         s_d.mv = MV_STOP;
      end

      // Overrun modes begin stopping once the inner limit is reached
      s_d.ovr_stop = (s_q.mode == SEL_OVR_A || s_q.mode == SEL_OVR_B)
                     && (actual_position >= s_q.act.inner);
   end

   // ---------------------------------------------------------------
   // Recipe memory: store and teach
   // ---------------------------------------------------------------
   // Kept out of the state struct so it can map onto a RAM
   always_ff @(posedge sys_clk) begin
      if (one_hot && rise[CW_RECIPE_STORE] && idx_slot) begin
         recipe_mem[recipe_index[5:0]] <= cyc;
      end else if (one_hot && rise[CW_TEACH] && idx_slot) begin
         recipe_mem[recipe_index[5:0]].learned <= actual_position;
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{act: RST_SET, cw_prev: 16'h0000, ack: 1'b0, head_outer: 1'b0,
                  head_inner: 1'b0, motor: 1'b0, ctrl_rst: 1'b0, mode_vld: 1'b0,
                  mode: SEL_NONE, err: 1'b0, diag: DIAG_OK, mv: MV_STOP,
                  ovr_stop: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   logic at_outer;
   logic at_learned;
   logic at_inner;
   logic [16:0] ovr_sum;

   always_comb begin
      at_outer   = in_window(actual_position, s_q.act.outer, s_q.act.window);
      at_learned = in_window(actual_position, s_q.act.learned, s_q.act.window);
      at_inner   = in_window(actual_position, s_q.act.inner, s_q.act.window);
      ovr_sum    = {1'b0, s_q.act.inner} + {1'b0, OVERRUN_CNT};
   end

   always_comb begin
      state_flags                 = 16'h0000;
      state_flags[SF_MOTOR_ON]    = s_q.motor;
      state_flags[SF_IN_MOTION]   = motion_busy;
      state_flags[SF_CREEP_OUTER] = s_q.mv == MV_CREEP_OUTER;
      state_flags[SF_CREEP_INNER] = s_q.mv == MV_CREEP_INNER;
      state_flags[SF_ALIVE]       = 1'b1;
      state_flags[SF_AT_OUTER]    = at_outer;
      state_flags[SF_AT_LEARNED]  = at_learned;
      state_flags[SF_AT_INNER]    = at_inner;
      state_flags[SF_UNDEFINED]   = !(at_outer || at_learned || at_inner);
      state_flags[SF_COMMIT_ACK]  = s_q.ack;
      state_flags[SF_HEAD_OUTER]  = s_q.head_outer;
      state_flags[SF_HEAD_INNER]  = s_q.head_inner;
      state_flags[SF_ERROR]       = s_q.err;
   end

   assign diagnosis       = s_q.diag;
   assign ctrl_mode_valid = s_q.mode_vld;
   assign ctrl_mode       = s_q.mode;
   assign ctrl_reset      = s_q.ctrl_rst;
   assign motor_enable    = s_q.motor;
   assign move_req        = s_q.mv;
   assign overrun_stop    = s_q.ovr_stop;
   assign overrun_limit   = ovr_sum[16] ? 16'hFFFF : ovr_sum[15:0];
   assign active_set      = s_q.act;

endmodule

// ===== logic/grip_cmd_pkg.sv
// Constants and types shared by the gripper process data command interpreter
package grip_cmd_pkg;

   // ---------------------------------------------------------------
   // Command word bit positions
   // ---------------------------------------------------------------
   localparam int unsigned CW_PARAM_COMMIT  = 0;
   localparam int unsigned CW_RECIPE_STORE  = 1;
   localparam int unsigned CW_CLEAR_HEADING = 2;
   localparam int unsigned CW_TEACH         = 3;
   localparam int unsigned CW_GO_OUTER      = 8;
   localparam int unsigned CW_GO_INNER      = 9;
   localparam int unsigned CW_CREEP_INNER   = 10;
   localparam int unsigned CW_CREEP_OUTER   = 11;

   // ---------------------------------------------------------------
   // Operating selector values
   // ---------------------------------------------------------------
   localparam logic [7:0] SEL_NONE      = 8'h00;
   localparam logic [7:0] SEL_IDLE      = 8'h01;
   localparam logic [7:0] SEL_CTRL_RST  = 8'h02;
   localparam logic [7:0] SEL_MOTOR_ON  = 8'h03;
   localparam logic [7:0] SEL_MOTOR_OFF = 8'h05;
   localparam logic [7:0] SEL_JOG       = 8'h0B;
   localparam logic [7:0] SEL_OVR_A     = 8'h3C;
   localparam logic [7:0] SEL_OVR_B     = 8'h50;
   localparam logic [15:0] CW_BASIC     = 16'h0001;

   // ---------------------------------------------------------------
   // Limits, units and state flag positions
   // ---------------------------------------------------------------
   localparam logic [7:0]  RECIPE_MAX     = 8'h20;
   localparam logic [7:0]  PCT_MIN        = 8'h01;
   localparam logic [7:0]  PCT_MAX        = 8'h64;
   localparam int unsigned POS_UNIT_UM    = 10;     // One count = 0.01 mm
   localparam int unsigned OVERRUN_UM     = 2000;   // Greatest overrun, 2 mm
   localparam logic [15:0] OVERRUN_CNT    = 16'(OVERRUN_UM / POS_UNIT_UM);
   localparam int unsigned SF_MOTOR_ON    = 1;
   localparam int unsigned SF_IN_MOTION   = 2;
   localparam int unsigned SF_CREEP_OUTER = 4;
   localparam int unsigned SF_CREEP_INNER = 5;
   localparam int unsigned SF_ALIVE       = 6;
   localparam int unsigned SF_AT_OUTER    = 8;
   localparam int unsigned SF_AT_LEARNED  = 9;
   localparam int unsigned SF_AT_INNER    = 10;
   localparam int unsigned SF_UNDEFINED   = 11;
   localparam int unsigned SF_COMMIT_ACK  = 12;
   localparam int unsigned SF_HEAD_OUTER  = 13;
   localparam int unsigned SF_HEAD_INNER  = 14;
   localparam int unsigned SF_ERROR       = 15;

   // ---------------------------------------------------------------
   // Fault codes and reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] DIAG_OK        = 16'h0000;
   localparam logic [15:0] DIAG_ORDER     = 16'h0101;
   localparam logic [15:0] DIAG_RANGE     = 16'h0102;
   localparam logic [7:0]  RST_PCT        = 8'h64;
   localparam logic [15:0] RST_POS        = 16'h0000;

   // Motion request towards the drive
   typedef enum logic [4:0] {
      MV_STOP        = 5'b00001,
      MV_OUTER       = 5'b00010,
      MV_INNER       = 5'b00100,
      MV_CREEP_OUTER = 5'b01000,
      MV_CREEP_INNER = 5'b10000
   } move_t;

   // One parameter set
   typedef struct packed {
      logic [7:0]  window;
      logic [7:0]  force_pct;
      logic [7:0]  speed_pct;
      logic [15:0] outer;
      logic [15:0] shift;
      logic [15:0] learned;
      logic [15:0] inner;
   } param_set_t;

   localparam param_set_t RST_SET = '{window: 8'h00, force_pct: RST_PCT,
      speed_pct: RST_PCT, outer: RST_POS, shift: RST_POS, learned: RST_POS,
      inner: RST_POS};

endpackage
